// *** inc/spp_pkg.sv ***
// Shared types and constants of the serial port block.
// Assumes a classic Wishbone master with 32-bit data and byte 0 carrying each register.
package spp_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } spp_wb_req_type;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } spp_wb_rsp_type;
  typedef enum logic [1:0] {MODE_SHIFT = 2'h0, MODE_UART8 = 2'h1, MODE_UART9F = 2'h2, MODE_UART9T = 2'h3} spp_mode_type;
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_WAIT = 2'h1, TX_SHIFT = 2'h3, TX_FLAG = 2'h2} spp_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_M0 = 2'h1, RX_MC = 2'h3, RX_M1 = 2'h2} spp_rx_state_type;
  // Register byte addresses
  localparam logic [31:0] OFS_SERIAL_CONTROL = 32'h0000_0000;
  localparam logic [31:0] OFS_SERIAL_BUFFER = 32'h0000_0004;
  localparam logic [31:0] OFS_POWER_CONTROL = 32'h0000_0008;
  localparam logic [31:0] OFS_CLOCK_CONTROL = 32'h0000_000C;
  localparam logic [31:0] OFS_T2_CONTROL = 32'h0000_0010;
  localparam logic [31:0] OFS_T1_RELOAD_HIGH = 32'h0000_0014;
  localparam logic [31:0] OFS_T2_RELOAD_LOW = 32'h0000_0018;
  localparam logic [31:0] OFS_T2_RELOAD_HIGH = 32'h0000_001C;
  // Field positions
  localparam int MODE_BIT0_POS = 7;
  localparam int MODE_BIT1_POS = 6;
  localparam int SPEED_MP_POS = 5;
  localparam int RX_EN_POS = 4;
  localparam int NINTH_TX_POS = 3;
  localparam int RX_NINTH_POS = 2;
  localparam int TX_DONE_POS = 1;
  localparam int RX_DONE_POS = 0;
  localparam int DOUBLE_BAUD_POS = 7;
  localparam int T2_PRESCALE_POS = 5;
  localparam int T1_PRESCALE_POS = 4;
  localparam int T2_RUN_POS = 1;
  localparam int T1_RUN_POS = 0;
  localparam int T2_OVF_POS = 7;
  localparam int T2_RX_CLK_POS = 5;
  localparam int T2_TX_CLK_POS = 4;
  localparam int T2_EXT_EN_POS = 3;
  // Reset value and frame constants
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [23:0] READ_PAD = 24'h00_0000;
  localparam logic START_BIT = 1'h0;
  localparam logic STOP_BIT = 1'h1;
  localparam logic [7:0] T1_MAX = 8'hFF;
  localparam logic [15:0] T2_MAX = 16'hFFFF;
  // Divide ratios and counter end points
  localparam logic [3:0] DIV_SLOW = 4'hC;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_T2_BAUD = 4'h2;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [3:0] M0_TX_LAST = 4'h7;
  localparam logic [3:0] M0_RX_BITS = 4'h8;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] MACH_LAST = 4'hB;
  localparam logic [1:0] TX_DLY_LAST = 2'h1;
endpackage

// *** verilog/spp_serial_port.sv ***
// Serial port with shift-register mode 0 and ten-bit UART mode 1, plus the baud timers.
// Assumes rxPinIn and t2ExtTrigger are synchronous to ref_clk and a Wishbone classic master.
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module spp_serial_port (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire spp_pkg::spp_wb_req_type wbReq,
  output spp_pkg::spp_wb_rsp_type wbRsp,
  input wire logic rxPinIn,
  output logic rxPinOut,
  output logic rxPinOen,
  output logic txPin,
  input wire logic t2ExtTrigger
);
  import spp_pkg::*;

  logic busAct, regWr, wrSctl, wrBuf, wrPwr, wrClk, wrT2c, wrT1r, wrT2l, wrT2h;
  logic [7:0] wrByte, readByte;
  spp_mode_type mode;
  logic [1:0] modeBits_q;
  logic speedMp_q, rxEn_q, ninthTx_q, rxNinth_q, txDone_q, rxDone_q;
  logic [7:0] power_q, clkCtl_q, t2Ctl_q, t1Reload_q, rxHold_q;
  logic [15:0] t2Reload_q;
  logic t2OvfFlag_q;

  assign busAct = wbReq.cyc & wbReq.stb;
  // Writes land on the edge where the master sees ack, never earlier
  assign regWr = busAct & wbReq.we & wbRsp.ack & wbReq.sel[0];
  assign wrByte = wbReq.dat[7:0];
  assign wrSctl = regWr & (wbReq.adr == OFS_SERIAL_CONTROL);
  assign wrBuf = regWr & (wbReq.adr == OFS_SERIAL_BUFFER);
  assign wrPwr = regWr & (wbReq.adr == OFS_POWER_CONTROL);
  assign wrClk = regWr & (wbReq.adr == OFS_CLOCK_CONTROL);
  assign wrT2c = regWr & (wbReq.adr == OFS_T2_CONTROL);
  assign wrT1r = regWr & (wbReq.adr == OFS_T1_RELOAD_HIGH);
  assign wrT2l = regWr & (wbReq.adr == OFS_T2_RELOAD_LOW);
  assign wrT2h = regWr & (wbReq.adr == OFS_T2_RELOAD_HIGH);
  assign mode = spp_mode_type'(modeBits_q);

  always_comb begin
    readByte = REG_RESET;
    case (wbReq.adr)
      OFS_SERIAL_CONTROL: readByte = {modeBits_q, speedMp_q, rxEn_q, ninthTx_q, rxNinth_q, txDone_q, rxDone_q};
      OFS_SERIAL_BUFFER: readByte = rxHold_q;
      OFS_POWER_CONTROL: readByte = power_q;
      OFS_CLOCK_CONTROL: readByte = clkCtl_q;
      OFS_T2_CONTROL: begin
        readByte = t2Ctl_q;
        readByte[T2_OVF_POS] = t2OvfFlag_q;
      end
      OFS_T1_RELOAD_HIGH: readByte = t1Reload_q;
      OFS_T2_RELOAD_LOW: readByte = t2Reload_q[7:0];
      OFS_T2_RELOAD_HIGH: readByte = t2Reload_q[15:8];
      default: readByte = REG_RESET;
    endcase
  end

  // Unmapped addresses still ack and read as zero so the master never hangs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= busAct & ~wbRsp.ack;
      wbRsp.dat <= {READ_PAD, readByte};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      power_q <= REG_RESET;
      clkCtl_q <= REG_RESET;
      t2Ctl_q <= REG_RESET;
      t1Reload_q <= REG_RESET;
      t2Reload_q <= {REG_RESET, REG_RESET};
    end else begin
      if (wrPwr) power_q <= wrByte;
      if (wrClk) clkCtl_q <= wrByte;
      if (wrT2c) t2Ctl_q <= wrByte;
      if (wrT1r) t1Reload_q <= wrByte;
      if (wrT2l) t2Reload_q[7:0] <= wrByte;
      if (wrT2h) t2Reload_q[15:8] <= wrByte;
    end
  end

  // Timer 1: eight-bit auto-reload counter
  logic [3:0] t1Pre_q, t1Div;
  logic [7:0] t1Count_q;
  logic t1Tick, t1Ovf_q, t1Half_q, t1Baud;
  assign t1Div = clkCtl_q[T1_PRESCALE_POS] ? DIV_FAST : DIV_SLOW;
  assign t1Tick = (t1Pre_q >= t1Div - 4'h1);
  assign t1Baud = t1Ovf_q & (power_q[DOUBLE_BAUD_POS] | t1Half_q);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t1Pre_q <= 4'h0;
      t1Count_q <= REG_RESET;
      t1Ovf_q <= 1'h0;
      t1Half_q <= 1'h0;
    end else begin
      t1Pre_q <= t1Tick ? 4'h0 : t1Pre_q + 4'h1;
      t1Ovf_q <= 1'h0;
      if (t1Ovf_q) t1Half_q <= ~t1Half_q;
      if (t1Tick && clkCtl_q[T1_RUN_POS]) begin
        if (t1Count_q == T1_MAX) begin
          t1Count_q <= t1Reload_q;
          t1Ovf_q <= 1'h1;
        end else begin
          t1Count_q <= t1Count_q + 8'h01;
        end
      end
    end
  end

  // Timer 2: sixteen-bit auto-reload counter, doubles as baud generator
  logic [3:0] t2Pre_q, t2Div;
  logic [15:0] t2Count_q;
  logic t2Tick, t2Ovf_q, t2ExtPrev_q, t2BaudMode, t2ExtReload, t2FlagSet;
  assign t2BaudMode = t2Ctl_q[T2_TX_CLK_POS] | t2Ctl_q[T2_RX_CLK_POS];
  assign t2Div = t2BaudMode ? DIV_T2_BAUD : (clkCtl_q[T2_PRESCALE_POS] ? DIV_FAST : DIV_SLOW);
  assign t2Tick = (t2Pre_q >= t2Div - 4'h1);
  assign t2ExtReload = ~t2BaudMode & t2Ctl_q[T2_EXT_EN_POS] & t2ExtPrev_q & ~t2ExtTrigger;
  assign t2FlagSet = t2Ovf_q & ~t2BaudMode;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t2Pre_q <= 4'h0;
      t2Count_q <= {REG_RESET, REG_RESET};
      t2Ovf_q <= 1'h0;
      t2ExtPrev_q <= 1'h1;
    end else begin
      t2Pre_q <= t2Tick ? 4'h0 : t2Pre_q + 4'h1;
      t2ExtPrev_q <= t2ExtTrigger;
      t2Ovf_q <= 1'h0;
      if (t2Tick && clkCtl_q[T2_RUN_POS] && t2Count_q == T2_MAX) begin
        t2Count_q <= t2Reload_q;
        t2Ovf_q <= 1'h1;
      end else if (t2ExtReload) begin
        t2Count_q <= t2Reload_q;
      end else if (t2Tick && clkCtl_q[T2_RUN_POS]) begin
        t2Count_q <= t2Count_q + 16'h0001;
      end
    end
  end

  // Set wins over a software clear landing in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) t2OvfFlag_q <= 1'h0;
    else t2OvfFlag_q <= t2FlagSet | (wrT2c ? wrByte[T2_OVF_POS] : t2OvfFlag_q);
  end

  // Sixteen-times baud ticks and their divide-by-16 counters
  logic txTick16, rxTick16, txRoll;
  logic [3:0] txDiv_q, rxDiv_q;
  assign txTick16 = t2Ctl_q[T2_TX_CLK_POS] ? t2Ovf_q : t1Baud;
  assign rxTick16 = t2Ctl_q[T2_RX_CLK_POS] ? t2Ovf_q : t1Baud;
  assign txRoll = txTick16 & (txDiv_q == OVS_LAST);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) txDiv_q <= 4'h0;
    else if (txTick16) txDiv_q <= txDiv_q + 4'h1;
  end

  // Mode 0 shift clock timing, shared by both directions
  spp_tx_state_type txState_q;
  spp_rx_state_type rxState_q;
  logic [3:0] m0Cnt_q, m0Div, m0Half, txBits_q, rxBits_q, rxMc_q;
  logic m0End, m0Rise, m0Active, m0Start, m0Finish, txStart0, txStart1, rxStart0, rxStart1;
  assign m0Div = speedMp_q ? DIV_FAST : DIV_SLOW;
  assign m0Half = m0Div >> 1;
  assign m0End = (m0Cnt_q == m0Div - 4'h1);
  assign m0Rise = (m0Cnt_q == m0Half);
  assign m0Active = (txState_q == TX_SHIFT && mode == MODE_SHIFT) || rxState_q == RX_M0;
  assign txStart0 = txState_q == TX_IDLE && wrBuf && mode == MODE_SHIFT && rxState_q == RX_IDLE;
  assign txStart1 = txState_q == TX_IDLE && wrBuf && mode == MODE_UART8;
  // A buffer write wins a tie with a receive start; mode 0 is half duplex
  assign rxStart0 = rxState_q == RX_IDLE && mode == MODE_SHIFT && rxEn_q && !rxDone_q
    && txState_q == TX_IDLE && !wrBuf;
  assign m0Start = txStart0 | rxStart0;
  assign m0Finish = (txState_q == TX_SHIFT && txBits_q == M0_TX_LAST) || (rxState_q == RX_M0 && rxBits_q == M0_RX_BITS);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) m0Cnt_q <= 4'h0;
    else if (m0Start || !m0Active || m0End) m0Cnt_q <= 4'h0;
    else m0Cnt_q <= m0Cnt_q + 4'h1;
  end

  // Transmitter
  logic [9:0] txShift_q;
  logic [1:0] txDly_q;
  logic txSet;
  assign txSet = (txState_q == TX_SHIFT && mode == MODE_SHIFT && m0End && txBits_q == M0_TX_LAST)
    || (txState_q == TX_FLAG && txDly_q == TX_DLY_LAST);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txState_q <= TX_IDLE;
      txShift_q <= '1;
      txBits_q <= 4'h0;
      txDly_q <= 2'h0;
    end else begin
      unique case (txState_q)
        TX_IDLE: begin
          txBits_q <= 4'h0;
          if (txStart0) begin
            txShift_q <= {STOP_BIT, STOP_BIT, wrByte};
            txState_q <= TX_SHIFT;
          end else if (txStart1) begin
            txShift_q <= {STOP_BIT, wrByte, START_BIT};
            txState_q <= TX_WAIT;
          end
        end
        TX_WAIT: if (txRoll) txState_q <= TX_SHIFT;
        TX_SHIFT: begin
          if (mode == MODE_SHIFT ? m0End : txRoll) begin
            txShift_q <= {STOP_BIT, txShift_q[9:1]};
            txBits_q <= txBits_q + 4'h1;
            if (mode == MODE_SHIFT && txBits_q == M0_TX_LAST) txState_q <= TX_IDLE;
            if (mode != MODE_SHIFT && txBits_q == FRAME_LAST) begin
              txState_q <= TX_FLAG;
              txDly_q <= 2'h0;
            end
          end
        end
        TX_FLAG: begin
          txDly_q <= txDly_q + 2'h1;
          if (txDly_q == TX_DLY_LAST) txState_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Line driving: shift clock in mode 0, serial data otherwise
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txPin <= 1'h1;
    end else if (mode == MODE_SHIFT) begin
      if (m0Start) txPin <= 1'h0;
      else if (m0Active && m0Rise) txPin <= 1'h1;
      else if (m0Active && m0End) txPin <= m0Finish;
      else if (!m0Active) txPin <= 1'h1;
    end else if (txState_q == TX_WAIT && txRoll) begin
      txPin <= txShift_q[0];
    end else if (txState_q == TX_SHIFT && txRoll) begin
      txPin <= txShift_q[1];
    end else if (txState_q == TX_IDLE) begin
      txPin <= 1'h1;
    end
  end

  // Data pin is only driven while mode 0 shifts out; released otherwise
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxPinOut <= 1'h1;
      rxPinOen <= 1'h1;
    end else if (txStart0) begin
      rxPinOut <= wrByte[0];
      rxPinOen <= 1'h0;
    end else if (txState_q == TX_SHIFT && mode == MODE_SHIFT && m0End) begin
      rxPinOut <= txShift_q[1];
      rxPinOen <= (txBits_q == M0_TX_LAST);
    end else if (!(txState_q == TX_SHIFT && mode == MODE_SHIFT)) begin
      rxPinOut <= 1'h1;
      rxPinOen <= 1'h1;
    end
  end

  // Receiver
  logic [7:0] rxShift_q;
  logic rxPrev_q, sampA_q, sampB_q, rxMid, rxBitEnd, maj, accept, rxSet;
  assign rxStart1 = rxState_q == RX_IDLE && mode == MODE_UART8 && rxEn_q && rxPrev_q && !rxPinIn;
  assign rxMid = rxTick16 && rxDiv_q == SAMPLE_C;
  assign rxBitEnd = rxTick16 && rxDiv_q == OVS_LAST;
  assign maj = (sampA_q & sampB_q) | (sampA_q & rxPinIn) | (sampB_q & rxPinIn);
  assign accept = rxState_q == RX_M1 && rxMid && rxBits_q == FRAME_LAST && !rxDone_q
    && (!speedMp_q || maj);
  assign rxSet = accept || (rxState_q == RX_MC && rxMc_q == MACH_LAST);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxPrev_q <= 1'h1;
      sampA_q <= 1'h1;
      sampB_q <= 1'h1;
      rxDiv_q <= 4'h0;
    end else begin
      rxPrev_q <= rxPinIn;
      if (rxTick16 && rxDiv_q == SAMPLE_A) sampA_q <= rxPinIn;
      if (rxTick16 && rxDiv_q == SAMPLE_B) sampB_q <= rxPinIn;
      if (rxStart1) rxDiv_q <= 4'h0;
      else if (rxTick16) rxDiv_q <= rxDiv_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxState_q <= RX_IDLE;
      rxShift_q <= REG_RESET;
      rxBits_q <= 4'h0;
      rxMc_q <= 4'h0;
    end else begin
      unique case (rxState_q)
        RX_IDLE: begin
          rxBits_q <= 4'h0;
          rxMc_q <= 4'h0;
          if (rxStart0) rxState_q <= RX_M0;
          else if (rxStart1) rxState_q <= RX_M1;
        end
        RX_M0: begin
          if (m0Rise) begin
            rxShift_q <= {rxPinIn, rxShift_q[7:1]};
            rxBits_q <= rxBits_q + 4'h1;
          end
          if (m0End && rxBits_q == M0_RX_BITS) rxState_q <= RX_MC;
        end
        RX_MC: begin
          rxMc_q <= rxMc_q + 4'h1;
          if (rxMc_q == MACH_LAST) rxState_q <= RX_IDLE;
        end
        RX_M1: begin
          if (rxMid && rxBits_q == 4'h0 && maj) rxState_q <= RX_IDLE;
          else if (rxMid && rxBits_q == FRAME_LAST) rxState_q <= RX_IDLE;
          else if (rxMid && rxBits_q != 4'h0) rxShift_q <= {maj, rxShift_q[7:1]};
          if (rxBitEnd) rxBits_q <= rxBits_q + 4'h1;
        end
      endcase
    end
  end

  // Holding register lets the next mode 1 word shift in while software reads this one
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rxHold_q <= REG_RESET;
    else if (rxState_q == RX_MC && rxMc_q == MACH_LAST) rxHold_q <= rxShift_q;
    else if (accept) rxHold_q <= rxShift_q;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      modeBits_q <= 2'h0;
      speedMp_q <= 1'h0;
      rxEn_q <= 1'h0;
      ninthTx_q <= 1'h0;
      rxNinth_q <= 1'h0;
      txDone_q <= 1'h0;
      rxDone_q <= 1'h0;
    end else begin
      if (wrSctl) begin
        modeBits_q <= {wrByte[MODE_BIT0_POS], wrByte[MODE_BIT1_POS]};
        speedMp_q <= wrByte[SPEED_MP_POS];
        rxEn_q <= wrByte[RX_EN_POS];
        ninthTx_q <= wrByte[NINTH_TX_POS];
      end
      rxNinth_q <= accept ? maj : (wrSctl ? wrByte[RX_NINTH_POS] : rxNinth_q);
      txDone_q <= txSet | (wrSctl ? wrByte[TX_DONE_POS] : txDone_q);
      rxDone_q <= rxSet | (wrSctl ? wrByte[RX_DONE_POS] : rxDone_q);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence stopEnd;
    txState_q == TX_SHIFT && mode == MODE_UART8 && txRoll && txBits_q == FRAME_LAST;
  endsequence
  sequence m0RxDone;
    rxState_q == RX_M0 ##1 rxState_q == RX_MC;
  endsequence

  a_ack_single: assert property (wbRsp.ack |=> !wbRsp.ack) else $error("ack held two cycles");
  a_tx_done_delay: assert property (stopEnd |-> !txSet ##1 !txSet ##1 txSet)
    else $error("transmit done not two cycles after stop");
  a_flag_sticky: assert property (txDone_q && !wrSctl |=> txDone_q) else $error("transmit done self-cleared");
  a_set_wins: assert property (rxSet |=> rxDone_q) else $error("receive done lost");
  a_m0_slow_low: assert property ($fell(txPin) && mode == MODE_SHIFT && !speedMp_q |-> !txPin[*7] ##1 txPin)
    else $error("slow shift clock low time wrong");
  a_m0_fast_low: assert property ($fell(txPin) && mode == MODE_SHIFT && speedMp_q |-> !txPin[*3] ##1 txPin)
    else $error("fast shift clock low time wrong");
  a_m0_rx_flag: assert property (m0RxDone |-> ##11 rxSet) else $error("mode 0 receive flag late");
  a_start_reject: assert property (rxState_q == RX_M1 && rxMid && rxBits_q == 4'h0 && maj |=> rxState_q == RX_IDLE)
    else $error("false start not abandoned");
  a_busy_discard: assert property (rxState_q == RX_M1 && rxMid && rxBits_q == FRAME_LAST && rxDone_q
    |=> $stable(rxHold_q) && rxState_q == RX_IDLE) else $error("frame taken while flag set");
  a_t2_reload: assert property (t2Tick && clkCtl_q[T2_RUN_POS] && t2Count_q == T2_MAX
    |=> t2Count_q == $past(t2Reload_q)) else $error("timer 2 reload wrong");
  a_t2_no_flag: assert property (t2Ovf_q && t2BaudMode && !wrT2c |=> $stable(t2OvfFlag_q))
    else $error("overflow flag set in baud use");
  a_idle_high: assert property (txState_q == TX_IDLE && rxState_q == RX_IDLE && $past(txState_q) == TX_IDLE
    |-> txPin) else $error("tx line not idle high");
  a_m0_drive: assert property (txState_q == TX_SHIFT && mode == MODE_SHIFT |-> !rxPinOen)
    else $error("data pin not driven in mode 0 send");
endmodule

// *** verif/spp_remote_model.sv ***
// Behavioural remote serial party: mode 0 shift register and mode 1 UART peer.
// Assumes the bench resolves the shared data line from the port's enable.
`timescale 1ns/100ps
module spp_remote_model (
  input wire logic ref_clk,
  input wire logic txPin,
  input wire logic dataIn,
  output logic lineOut
);
  logic [7:0] got;
  logic gotStop;
  initial lineOut = 1'b1;
  // Shift register clocked by the port's shift clock
  task automatic m0_take();
    for (int i = 0; i < 8; i++) begin
      @(posedge txPin);
      got[i] = dataIn;
    end
  endtask
  // Data moves just after each rise, so the port's sample at the rise sees a settled bit
  task automatic m0_give(input logic [7:0] b);
    lineOut = b[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge txPin);
      lineOut = b[i];
    end
    @(posedge txPin);
    // Past the hold, show the inverse rather than a stale level
    lineOut = ~b[7];
  endtask
  task automatic m1_send(input logic [7:0] b, input logic stopv, input int bitClk);
    logic [9:0] f;
    f = {stopv, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      lineOut <= f[i];
      repeat (bitClk) @(posedge ref_clk);
    end
    lineOut <= 1'b1;
  endtask
  task automatic m1_take(input int bitClk);
    @(negedge txPin);
    repeat (bitClk / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitClk) @(posedge ref_clk);
      got[i] = txPin;
    end
    repeat (bitClk) @(posedge ref_clk);
    gotStop = txPin;
  endtask
endmodule

// *** verif/tb_spp_serial_port.sv ***
// Self-checking bench for the serial port: Wishbone register calls plus a remote peer.
// Assumes a 25 MHz clock and Timer 2 at reload 0xFFFF giving 32 clocks per UART bit.
`timescale 1ns/100ps
module tb_spp_serial_port;
  import spp_pkg::*;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
$display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
  logic ref_clk, rstn, t2ExtTrigger, lineOut;
  logic rxPinIn, rxPinOut, rxPinOen, txPin;
  spp_wb_req_type wbReq;
  spp_wb_rsp_type wbRsp;
  int err_count = 0;
  int compares = 0;
  logic [7:0] q;
  time lastRise = 0;
  time risePeriod = 0;
  assign rxPinIn = rxPinOen ? lineOut : rxPinOut;
  spp_serial_port spp_serial_port_i (.ref_clk(ref_clk), .rstn(rstn), .wbReq(wbReq), .wbRsp(wbRsp),
    .rxPinIn(rxPinIn), .rxPinOut(rxPinOut), .rxPinOen(rxPinOen), .txPin(txPin),
    .t2ExtTrigger(t2ExtTrigger));
  spp_remote_model spp_remote_model_i (.ref_clk(ref_clk), .txPin(txPin), .dataIn(rxPinIn),
    .lineOut(lineOut));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge txPin) begin
    risePeriod = $time - lastRise;
    lastRise = $time;
  end
  task automatic give_verdict();
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic [31:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
    int n;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: a, dat: {24'h0, d}};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      give_verdict();
    end
    r = wbRsp.dat[7:0];
    wbReq <= '0;
    @(posedge ref_clk);
  endtask
  // Polls a serial_control flag; the bound covers a full UART frame
  task automatic poll(input int pos);
    int n;
    logic [7:0] r;
    n = 0;
    do begin
      wb(OFS_SERIAL_CONTROL, 1'b0, 8'h00, r);
      n++;
    end while (r[pos] !== 1'b1 && n < 400);
    `CHK(r[pos], 1'b1)
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end
  initial begin
    rstn = 1'b0;
    t2ExtTrigger = 1'b1;
    wbReq = '0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    `CHK(txPin, 1'b1)
    `CHK(rxPinOen, 1'b1)
    wb(OFS_SERIAL_CONTROL, 1'b0, 8'h00, q);
    `CHK(q, REG_RESET)
    wb(32'h0000_0040, 1'b1, 8'h55, q);
    wb(32'h0000_0040, 1'b0, 8'h00, q);
    `CHK(q, 8'h00)
    for (int s = 0; s < 2; s++) begin
      wb(OFS_SERIAL_CONTROL, 1'b1, s ? 8'h20 : 8'h00, q);
      fork
        wb(OFS_SERIAL_BUFFER, 1'b1, s ? 8'hC3 : 8'hA5, q);
        spp_remote_model_i.m0_take();
      join
      `CHK(spp_remote_model_i.got, s ? 8'hC3 : 8'hA5)
      `CHK(risePeriod, s ? 160 : 480)
      poll(TX_DONE_POS);
      `CHK(rxPinOen, 1'b1)
    end
    fork
      wb(OFS_SERIAL_CONTROL, 1'b1, 8'h30, q);
      spp_remote_model_i.m0_give(8'h3C);
    join
    poll(RX_DONE_POS);
    repeat (60) @(posedge ref_clk);
    `CHK(txPin, 1'b1)
    wb(OFS_SERIAL_CONTROL, 1'b0, 8'h00, q);
    `CHK(q[RX_DONE_POS], 1'b1)
    wb(OFS_SERIAL_BUFFER, 1'b0, 8'h00, q);
    `CHK(q, 8'h3C)
    wb(OFS_T2_RELOAD_LOW, 1'b1, 8'hFF, q);
    wb(OFS_T2_RELOAD_HIGH, 1'b1, 8'hFF, q);
    // Timer 2 leaves reset at zero; a trigger reload before baud use loads the top so ticks start at once
    wb(OFS_T2_CONTROL, 1'b1, 8'h08, q);
    t2ExtTrigger <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t2ExtTrigger <= 1'b1;
    @(posedge ref_clk);
    wb(OFS_T2_CONTROL, 1'b1, 8'h38, q);
    wb(OFS_CLOCK_CONTROL, 1'b1, 8'h03, q);
    wb(OFS_SERIAL_CONTROL, 1'b1, 8'h50, q);
    fork
      wb(OFS_SERIAL_BUFFER, 1'b1, 8'h96, q);
      spp_remote_model_i.m1_take(32);
      begin
        repeat (5) @(posedge ref_clk);
        t2ExtTrigger <= 1'b0;
        spp_remote_model_i.m1_send(8'h5A, 1'b1, 32);
      end
    join
    `CHK(spp_remote_model_i.got, 8'h96)
    `CHK(spp_remote_model_i.gotStop, 1'b1)
    poll(TX_DONE_POS);
    poll(RX_DONE_POS);
    wb(OFS_SERIAL_BUFFER, 1'b0, 8'h00, q);
    `CHK(q, 8'h5A)
    wb(OFS_SERIAL_CONTROL, 1'b0, 8'h00, q);
    `CHK(q[RX_NINTH_POS], 1'b1)
    wb(OFS_T2_CONTROL, 1'b0, 8'h00, q);
    `CHK(q[T2_OVF_POS], 1'b0)
    t2ExtTrigger <= 1'b1;
    wb(OFS_SERIAL_CONTROL, 1'b1, 8'h70, q);
    spp_remote_model_i.m1_send(8'h11, 1'b0, 32);
    repeat (40) @(posedge ref_clk);
    // A two-clock low pulse must fail the start majority
    spp_remote_model_i.m1_send(8'hFF, 1'b1, 2);
    repeat (40) @(posedge ref_clk);
    wb(OFS_SERIAL_CONTROL, 1'b0, 8'h00, q);
    `CHK(q[RX_DONE_POS], 1'b0)
    wb(OFS_SERIAL_BUFFER, 1'b0, 8'h00, q);
    `CHK(q, 8'h5A)
    spp_remote_model_i.m1_send(8'hE7, 1'b1, 32);
    poll(RX_DONE_POS);
    wb(OFS_SERIAL_BUFFER, 1'b0, 8'h00, q);
    `CHK(q, 8'hE7)
    spp_remote_model_i.m1_send(8'h3B, 1'b1, 32);
    wb(OFS_SERIAL_BUFFER, 1'b0, 8'h00, q);
    `CHK(q, 8'hE7)
    wb(OFS_T1_RELOAD_HIGH, 1'b1, 8'hFF, q);
    wb(OFS_POWER_CONTROL, 1'b1, 8'h80, q);
    wb(OFS_T2_CONTROL, 1'b1, 8'h18, q);
    wb(OFS_CLOCK_CONTROL, 1'b1, 8'h13, q);
    wb(OFS_SERIAL_CONTROL, 1'b1, 8'h50, q);
    // Timer 1 reaches its first reload within 256 ticks of four clocks
    repeat (1200) @(posedge ref_clk);
    spp_remote_model_i.m1_send(8'h4D, 1'b1, 64);
    poll(RX_DONE_POS);
    wb(OFS_SERIAL_BUFFER, 1'b0, 8'h00, q);
    `CHK(q, 8'h4D)
    give_verdict();
  end
endmodule
